// File: pixel_mirror_map.vh
`ifndef PIXEL_MIRROR_MAP_VH
`define PIXEL_MIRROR_MAP_VH

// ==========================================================
// pixel and tone table geometry
`define PIX_W             12
`define TABLE_DEPTH       4096
`define TABLE_AW          12
`define TABLE_STEP_SHIFT  3
`define TABLE_STEP        8
`define TABLE_LAST_POINT  12'h0FF8
`define SEGMENT_LAST      9'h1FF
`define NARROW_SHIFT      4

// ==========================================================
// table selector codes
`define TABLE_SEL_W        2
`define TABLE_SEL_LUMA     2'h0

// ==========================================================
// color filter phase codes
`define CFA_W             2
`define CFA_PHASE_GB      2'h1

// ==========================================================
// control state reset values
`define FLIP_RESET        1'b0

`endif

// File: pixel_mirror_and_tone_lut.v
// Contract
// - with horizontal flip on, each line leaves in reversed pixel order.
// - with vertical flip on, lines of a frame leave in reversed order.
// - both flips may be active at once, mirroring on both axes.
// - mirroring is applied to each whole captured frame before it is sent.
// - on color parts the filter phase reported stays GB for any flip setting.
// - measurement windows stay in sensor coordinates, unaffected by mirroring.
// - tone mapping takes 12-bit samples and gives 12-bit results.
// - table off and 12-bit format: the 12 digitizer bits pass unchanged.
// - the table holds 4096 locations, 0 to 4095, each 12 bits.
// - only locations at multiples of 8 define outputs; others are ignored.
// - inputs between points interpolate linearly between neighbouring multiples of 8.
// - inputs above 4088 take entry 4088 directly; locations 4089-4095 unused.
// - 8-bit format with table on: map to 12 bits, then keep top 8.
// - the selector offers only the luminance table.
// - the index picks the location the next value write targets, from 0.
// - a value write stores the 12-bit number at the indexed location.
// - a separate enable switches the table in; cleared means bypass.
`timescale 1ns/1ps
`include "pixel_mirror_map.vh"

module pixel_mirror_and_tone_lut #(
    parameter COL_W = 4,                               // log2 of widest line held
    parameter ROW_W = 4                                // log2 of tallest frame held
) (
    input  wire                    ref_clk,                 // pixel clock, 200 MHz
    input  wire                    rst,                     // synchronous reset, high
    input  wire                    in_valid,                // digitizer pixel valid
    output reg                     in_ready,                // block accepts pixel
    input  wire [`PIX_W-1:0]       in_pixel,                // digitized sample
    input  wire                    in_line_end,             // last pixel of a line
    input  wire                    in_frame_end,            // last pixel of a frame
    output reg                     out_valid,               // transmit pixel valid
    input  wire                    out_ready,               // transmit side accepts
    output reg  [`PIX_W-1:0]       out_pixel,               // mapped pixel
    output reg                     out_line_end,            // last pixel of a line
    output reg                     out_frame_end,           // last pixel of a frame
    input  wire                    horizontal_flip_enable,  // mirror about line center
    input  wire                    vertical_flip_enable,    // mirror top to bottom
    input  wire                    out_format_8bit,         // 1: 8-bit output format
    input  wire [`TABLE_SEL_W-1:0] tone_table_select,       // table selector
    input  wire [`TABLE_AW-1:0]    tone_table_index,        // table location
    input  wire [`PIX_W-1:0]       tone_table_value,        // value to write
    input  wire                    tone_table_value_write,  // write strobe
    input  wire                    tone_table_enable,       // table in pixel path
    output reg  [`PIX_W-1:0]       tone_table_readback,     // value at index
    output reg  [`CFA_W-1:0]       cfa_phase,               // output filter phase
    output reg                     meas_valid,              // pixel seen by auto window
    output reg  [COL_W-1:0]        meas_col,                // sensor column of it
    output reg  [ROW_W-1:0]        meas_row                 // sensor row of it
);

    localparam S_CAPTURE = 2'b01;
    localparam S_PLAY    = 2'b10;
    localparam STORE_AW  = COL_W + ROW_W;
    localparam STORE_N   = 1 << STORE_AW;

    // ==========================================================
    // helpers
    function [15:0] mirror_pos;
        input [15:0] pos;
        input [15:0] last;
        input        en;
        begin
            mirror_pos = en ? (last - pos) : pos;
        end
    endfunction

    function [`TABLE_AW-1:0] point_addr;
        input [8:0] segment;
        begin
            point_addr = {segment, 3'h0};
        end
    endfunction

    // weights sum to the point spacing, so the divide is a shift that truncates downward
    function [`PIX_W-1:0] tone_lerp;
        input [`PIX_W-1:0] lo;
        input [`PIX_W-1:0] hi;
        input [2:0]        fr;
        reg   [15:0]       sum;
        begin
            sum       = lo * (4'h8 - {1'b0, fr}) + hi * {1'b0, fr};
            tone_lerp = sum[`PIX_W+`TABLE_STEP_SHIFT-1:`TABLE_STEP_SHIFT];
        end
    endfunction

    // ==========================================================
    // storage
    reg [`PIX_W-1:0] frame_store [0:STORE_N-1];
    reg [`PIX_W-1:0] tone_table  [0:`TABLE_DEPTH-1];

    reg [1:0]       state;
    reg [1:0]       next_state;
    reg [COL_W-1:0] cap_col;
    reg [ROW_W-1:0] cap_row;
    reg [COL_W-1:0] last_col;
    reg [ROW_W-1:0] last_row;
    reg             hflip;
    reg             vflip;
    reg [COL_W-1:0] play_col;
    reg [ROW_W-1:0] play_row;
    reg [COL_W-1:0] next_cap_col;
    reg [ROW_W-1:0] next_cap_row;
    reg [COL_W-1:0] next_play_col;
    reg [ROW_W-1:0] next_play_row;

    reg                   skid_valid;
    reg [`PIX_W-1:0]      skid_pixel;
    reg                   skid_line_end;
    reg                   skid_frame_end;

    wire accept    = in_ready & in_valid;
    wire buf_ready = ~skid_valid;
    wire play_on   = state[1];
    wire push      = play_on & buf_ready;
    wire head_free = ~out_valid | out_ready;

    // ==========================================================
    // playback addressing
    wire [15:0]      src_col_wide = mirror_pos({{(16-COL_W){1'b0}}, play_col},
                                               {{(16-COL_W){1'b0}}, last_col}, hflip);
    wire [15:0]      src_row_wide = mirror_pos({{(16-ROW_W){1'b0}}, play_row},
                                               {{(16-ROW_W){1'b0}}, last_row}, vflip);
    wire [COL_W-1:0] src_col      = src_col_wide[COL_W-1:0];
    wire [ROW_W-1:0] src_row      = src_row_wide[ROW_W-1:0];
    wire [`PIX_W-1:0] raw_pixel  = frame_store[{src_row, src_col}];
    wire              play_le    = (play_col == last_col);
    wire              play_fe    = play_le & (play_row == last_row);

    // ==========================================================
    // tone mapping
    wire [8:0]        seg      = raw_pixel[`PIX_W-1:`TABLE_STEP_SHIFT];
    wire [2:0]        frac     = raw_pixel[`TABLE_STEP_SHIFT-1:0];
    wire [8:0]        seg_next = seg + 9'h001;
    wire [`PIX_W-1:0] lo_val   = tone_table[point_addr(seg)];
    wire [`PIX_W-1:0] hi_val   = tone_table[point_addr(seg_next)];
    wire [`PIX_W-1:0] interp   = tone_lerp(lo_val, hi_val, frac);
    wire [`PIX_W-1:0] mapped   = (seg == `SEGMENT_LAST) ? lo_val : interp;
    wire [`PIX_W-1:0] chosen   = tone_table_enable ? mapped : raw_pixel;
    wire [`PIX_W-1:0] formatted = out_format_8bit ?
                                  {4'h0, chosen[`PIX_W-1:`NARROW_SHIFT]} : chosen;

    // ==========================================================
    // frame sequencing
    always @* begin
        next_state = state;
        case (state)
            S_CAPTURE: begin
                if (accept && in_frame_end) begin
                    next_state = S_PLAY;
                end
            end
            S_PLAY: begin
                if (push && play_fe) begin
                    next_state = S_CAPTURE;
                end
            end
            default: begin
                next_state = S_CAPTURE;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            state    <= S_CAPTURE;
            in_ready <= 1'b0;
        end else begin
            state    <= next_state;
            in_ready <= (next_state == S_CAPTURE);
        end
    end

    // ==========================================================
    // capture position
    // a frame end also closes its line, so it clears both counters
    always @* begin
        next_cap_col = cap_col;
        next_cap_row = cap_row;
        if (accept) begin
            if (in_frame_end) begin
                next_cap_col = {COL_W{1'b0}};
                next_cap_row = {ROW_W{1'b0}};
            end else if (in_line_end) begin
                next_cap_col = {COL_W{1'b0}};
                next_cap_row = cap_row + {{(ROW_W-1){1'b0}}, 1'b1};
            end else begin
                next_cap_col = cap_col + {{(COL_W-1){1'b0}}, 1'b1};
            end
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            cap_col <= {COL_W{1'b0}};
            cap_row <= {ROW_W{1'b0}};
        end else begin
            cap_col <= next_cap_col;
            cap_row <= next_cap_row;
        end
    end

    // the last line's length sets the width, so every line of a frame must match
    always @(posedge ref_clk) begin
        if (rst) begin
            last_col <= {COL_W{1'b0}};
            last_row <= {ROW_W{1'b0}};
        end else if (accept) begin
            if (in_line_end || in_frame_end) begin
                last_col <= cap_col;
            end
            if (in_frame_end) begin
                last_row <= cap_row;
            end
        end
    end

    // flips are sampled per frame so a change never tears an image
    always @(posedge ref_clk) begin
        if (rst) begin
            hflip <= `FLIP_RESET;
            vflip <= `FLIP_RESET;
        end else if (accept && in_frame_end) begin
            hflip <= horizontal_flip_enable;
            vflip <= vertical_flip_enable;
        end
    end

    // ==========================================================
    // playback position
    always @* begin
        next_play_col = play_col;
        next_play_row = play_row;
        if (accept && in_frame_end) begin
            next_play_col = {COL_W{1'b0}};
            next_play_row = {ROW_W{1'b0}};
        end else if (push) begin
            if (play_le) begin
                next_play_col = {COL_W{1'b0}};
                next_play_row = play_row + {{(ROW_W-1){1'b0}}, 1'b1};
            end else begin
                next_play_col = play_col + {{(COL_W-1){1'b0}}, 1'b1};
            end
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            play_col <= {COL_W{1'b0}};
            play_row <= {ROW_W{1'b0}};
        end else begin
            play_col <= next_play_col;
            play_row <= next_play_row;
        end
    end

    // lines longer than the store wrap onto themselves; size COL_W/ROW_W for the sensor
    always @(posedge ref_clk) begin
        if (accept) begin
            frame_store[{cap_row, cap_col}] <= in_pixel;
        end
    end

    // ==========================================================
    // auto-function tap, sensor coordinates regardless of flips
    always @(posedge ref_clk) begin
        if (rst) begin
            meas_valid <= 1'b0;
            meas_col   <= {COL_W{1'b0}};
            meas_row   <= {ROW_W{1'b0}};
            cfa_phase  <= `CFA_PHASE_GB;
        end else begin
            meas_valid <= accept;
            meas_col   <= cap_col;
            meas_row   <= cap_row;
            // readout origin is kept on a GB site so mirroring never moves the phase
            cfa_phase  <= `CFA_PHASE_GB;
        end
    end

    // ==========================================================
    // tone table access
    wire table_write = tone_table_value_write & (tone_table_select == `TABLE_SEL_LUMA);

    always @(posedge ref_clk) begin
        if (table_write) begin
            tone_table[tone_table_index] <= tone_table_value;
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            tone_table_readback <= {`PIX_W{1'b0}};
        end else begin
            tone_table_readback <= tone_table[tone_table_index];
        end
    end

    // ==========================================================
    // two-entry output buffer: head drives the ports, skid catches a stall
    always @(posedge ref_clk) begin
        if (rst) begin
            out_valid     <= 1'b0;
            out_pixel     <= {`PIX_W{1'b0}};
            out_line_end  <= 1'b0;
            out_frame_end <= 1'b0;
        end else if (head_free) begin
            if (skid_valid) begin
                out_valid     <= 1'b1;
                out_pixel     <= skid_pixel;
                out_line_end  <= skid_line_end;
                out_frame_end <= skid_frame_end;
            end else if (push) begin
                out_valid     <= 1'b1;
                out_pixel     <= formatted;
                out_line_end  <= play_le;
                out_frame_end <= play_fe;
            end else begin
                out_valid <= 1'b0;
            end
        end
    end

    // a stalled head parks the next word here; playback waits until the skid drains
    always @(posedge ref_clk) begin
        if (rst) begin
            skid_valid     <= 1'b0;
            skid_pixel     <= {`PIX_W{1'b0}};
            skid_line_end  <= 1'b0;
            skid_frame_end <= 1'b0;
        end else if (head_free && skid_valid) begin
            skid_valid     <= 1'b0;
        end else if (push && !head_free) begin
            skid_valid     <= 1'b1;
            skid_pixel     <= formatted;
            skid_line_end  <= play_le;
            skid_frame_end <= play_fe;
        end
    end

endmodule // pixel_mirror_and_tone_lut

// File: mirror_lut_checker_sva.sv
`timescale 1ns/1ps
// ========================================
// stream and table port checks
module mirror_lut_checker (
    input wire        ref_clk,       // clock
    input wire        rst,           // reset
    input wire        in_valid,      // offered
    input wire        in_ready,      // taken
    input wire        in_frame_end,  // marker in
    input wire        out_valid,     // offered
    input wire        out_ready,     // taken
    input wire [11:0] out_pixel,     // word
    input wire        out_line_end,  // marker
    input wire        out_frame_end, // marker
    input wire [1:0]  tone_table_select,      // selector
    input wire [11:0] tone_table_index,       // location
    input wire [11:0] tone_table_value,       // data
    input wire        tone_table_value_write, // strobe
    input wire [11:0] tone_table_readback,    // contents
    input wire [1:0]  cfa_phase,     // phase
    input wire        meas_valid     // window strobe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire take = in_valid && in_ready;
    chk_cfa_phase_gb: assert property (cfa_phase == 2'h1)
        else $error("filter phase left GB");
    chk_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_pixel)
        && $stable(out_line_end) && $stable(out_frame_end)) else $error("stalled output changed");
    chk_meas_follow: assert property (take |=> meas_valid)
        else $error("window strobe missing");
    chk_meas_idle: assert property (!take |=> !meas_valid)
        else $error("window strobe without pixel");
    chk_ready_drop: assert property (take && in_frame_end |=> !in_ready [*8])
        else $error("input accepted during playback");
    chk_play_start: assert property (take && in_frame_end |-> ##[1:3] out_valid)
        else $error("playback did not start");
    // index must hold two cycles, the readback lags the table by one
    chk_table_write: assert property (tone_table_value_write && tone_table_select == 2'h0
        ##1 ($stable(tone_table_index) && !tone_table_value_write) ##1 $stable(tone_table_index)
        |=> tone_table_readback == $past(tone_table_value, 3)) else $error("table write lost");
    chk_reset_idle: assert property (disable iff (1'b0) rst |=> !in_ready && !out_valid)
        else $error("stream active in reset");
    cover property (take && in_frame_end);
    cover property (out_valid && !out_ready);
    cover property (tone_table_value_write && tone_table_select != 2'h0);
endmodule // mirror_lut_checker
bind pixel_mirror_and_tone_lut mirror_lut_checker chk_u (.ref_clk(ref_clk), .rst(rst), .in_valid(in_valid),
    .in_ready(in_ready), .in_frame_end(in_frame_end), .out_valid(out_valid), .out_ready(out_ready),
    .out_pixel(out_pixel), .out_line_end(out_line_end), .out_frame_end(out_frame_end),
    .tone_table_select(tone_table_select), .tone_table_index(tone_table_index),
    .tone_table_value(tone_table_value), .tone_table_value_write(tone_table_value_write),
    .tone_table_readback(tone_table_readback), .cfa_phase(cfa_phase), .meas_valid(meas_valid));

// File: stream_sink.sv
`timescale 1ns/1ps
// ========================================
// transmit side: takes words, stalls one cycle in four
module stream_sink (
    input  wire        ref_clk,       // clock
    input  wire        rst,           // reset
    input  wire        clear,         // restart capture
    input  wire        out_valid,     // offered
    output logic       out_ready,     // taken
    input  wire [11:0] out_pixel,     // word
    input  wire        out_line_end,  // marker
    input  wire        out_frame_end  // marker
);
    logic [1:0]  phase;
    logic [13:0] cap [0:15];
    int          cnt;
    always @(posedge ref_clk) begin
        phase <= rst ? 2'h0 : phase + 2'h1;
        out_ready <= !rst && phase != 2'h3;
        if (clear) cnt <= 0;
        else if (out_valid && out_ready) begin
            cap[cnt[3:0]] <= {out_frame_end, out_line_end, out_pixel};
            cnt <= cnt + 1;
        end
    end
endmodule // stream_sink

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    // ========================================
    // stimulus and hookup
    logic        ref_clk = '0, rst = '1, in_valid = '0, in_le = '0, in_fe = '0, hflip = '0, vflip = '0;
    logic        fmt8 = '0, wr = '0, tbl_en = '0, clear = '0;
    logic [11:0] in_pixel = '0, idx = '0, val = '0;
    logic [1:0]  sel = '0;
    wire         in_ready, out_valid, out_ready, out_le, out_fe, meas_valid;
    wire  [11:0] out_pixel, readback;
    wire  [1:0]  cfa, mcol, mrow;
    int          bad_count = 0, tests_run = 0;
    logic [11:0] tv [0:511];
    logic [11:0] px [0:15] = '{12'h000, 12'h007, 12'h00C, 12'hFF8, 12'hFFF, 12'hFF9, 12'hFF7, 12'h001,
                               12'h123, 12'h456, 12'h789, 12'hABC, 12'hDEF, 12'h010, 12'h808, 12'h3FD};
    pixel_mirror_and_tone_lut #(.COL_W(2), .ROW_W(2)) dut_u (.ref_clk(ref_clk), .rst(rst), .in_valid(in_valid),
        .in_ready(in_ready), .in_pixel(in_pixel), .in_line_end(in_le), .in_frame_end(in_fe), .out_valid(out_valid),
        .out_ready(out_ready), .out_pixel(out_pixel), .out_line_end(out_le), .out_frame_end(out_fe),
        .horizontal_flip_enable(hflip), .vertical_flip_enable(vflip), .out_format_8bit(fmt8),
        .tone_table_select(sel), .tone_table_index(idx), .tone_table_value(val), .tone_table_value_write(wr),
        .tone_table_enable(tbl_en), .tone_table_readback(readback), .cfa_phase(cfa), .meas_valid(meas_valid),
        .meas_col(mcol), .meas_row(mrow));
    stream_sink sink_u (.ref_clk(ref_clk), .rst(rst), .clear(clear), .out_valid(out_valid),
        .out_ready(out_ready), .out_pixel(out_pixel), .out_line_end(out_le), .out_frame_end(out_fe));
    initial forever #2.5 ref_clk = ~ref_clk;
    // ========================================
    // shared tasks
    task check(input logic [13:0] seen, input logic [13:0] expected);
        tests_run++;
        if (seen !== expected) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, expected);
        end
    endtask
    task complete_run;
        if (bad_count == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task give_up;
        bad_count++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        complete_run;
    endtask
    task tick;
        @(posedge ref_clk);
        #1;
    endtask
    task put(input logic [11:0] i, input logic [11:0] d, input logic [1:0] s);
        idx = i;
        val = d;
        sel = s;
        wr = 1'b1;
        tick;
    endtask
    task peek(input logic [11:0] i, input logic [11:0] d);
        wr = 1'b0;
        idx = i;
        tick;
        tick;
        check({2'h0, readback}, {2'h0, d});
    endtask
    function automatic logic [11:0] mapped(input logic [11:0] p, input logic t, input logic f8);
        int s, f, m;
        s = p >> 3;
        f = p & 7;
        m = !t ? p : (p >= 12'hFF8) ? tv[511] : (tv[s] * (8 - f) + tv[s + 1] * f) / 8;
        return f8 ? {4'h0, m[11:4]} : m[11:0];
    endfunction
    // one 4x4 frame in, compared in mirrored order; the sink stalls meanwhile
    task run_frame(input logic h, input logic v, input logic t, input logic f8);
        int n, r, c;
        hflip = h;
        vflip = v;
        tbl_en = t;
        fmt8 = f8;
        clear = 1'b1;
        tick;
        clear = 1'b0;
        for (int k = 0; k < 16; k++) begin
            in_valid = 1'b1;
            in_pixel = px[k];
            in_le = (k % 4 == 3);
            in_fe = (k == 15);
            for (n = 0; in_ready !== 1'b1 && n < 100; n++) tick;
            if (n == 100) give_up;
            tick;
            check({meas_valid, 9'h000, mrow, mcol}, {1'b1, 9'h000, 2'(k / 4), 2'(k % 4)});
        end
        in_valid = 1'b0;
        for (n = 0; sink_u.cnt < 16 && n < 300; n++) tick;
        if (n == 300) give_up;
        for (int j = 0; j < 16; j++) begin
            r = v ? 3 - j / 4 : j / 4;
            c = h ? 3 - j % 4 : j % 4;
            check(sink_u.cap[j], {j == 15, j % 4 == 3, mapped(px[r * 4 + c], t, f8)});
        end
    endtask
    // ========================================
    // scenarios
    task plain_bypass; run_frame(1'b0, 1'b0, 1'b0, 1'b0); endtask
    task flip_h; run_frame(1'b1, 1'b0, 1'b0, 1'b0); endtask
    task flip_v; run_frame(1'b0, 1'b1, 1'b0, 1'b0); endtask
    task flip_both; run_frame(1'b1, 1'b1, 1'b0, 1'b0); endtask
    task load_table;
        for (int s = 0; s < 512; s++) put(12'(s * 8), tv[s], 2'h0);
        put(12'hFFF, 12'h000, 2'h0);
        put(12'h008, 12'h5A5, 2'h1);
        put(12'h00C, 12'hABC, 2'h0);
        peek(12'h00C, 12'hABC);
        peek(12'h008, tv[1]);
    endtask
    task mapped_wide; run_frame(1'b0, 1'b0, 1'b1, 1'b0); endtask
    task mapped_narrow; run_frame(1'b1, 1'b1, 1'b1, 1'b1); endtask
    initial begin
        for (int s = 0; s < 512; s++) tv[s] = 12'(s * s * 3 + s * 7);
        repeat (16) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        plain_bypass;
        flip_h;
        flip_v;
        flip_both;
        load_table;
        mapped_wide;
        mapped_narrow;
        complete_run;
    end
endmodule // tb_top
